// ---- bench/azs_master.sv ----
// Purpose: Mode 3 serial master driving the sensor link.
// Assumes: 200 ns link period, 8 core clocks.
// Notes:   Link clock stands high between frames.
`timescale 1ns/1ps
module azs_master (
  // Pacing clock
  input  wire logic clk_in,
  // Link pins
  input  wire logic miso_in,
  output logic      sclk_out = 1'b1,
  output logic      cs_n_out = 1'b1,
  output logic      mosi_out = 1'b0
);
  // 16 bits each way, MSB first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_in) cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      sclk_out <= 1'b0;
      mosi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      @(posedge clk_in);
      rx[i] = miso_in; // One clock late, clear of the output update
      repeat (3) @(posedge clk_in);
    end
    cs_n_out <= 1'b1;
    mosi_out <= ~tx[0]; // Released line flips so a stale bit cannot pass
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ---- bench/azs_sva.sv ----
// Purpose: Port checks for the angle sensor serial slave.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes:   Attached to every azs_spi_top by bind.
`timescale 1ns/1ps
module azs_spi_top_sva (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Watched pins and status
  input wire logic       spi_cs_n_in,
  input wire logic       spi_miso_out,
  input wire logic       spi_miso_oe_out,
  input wire logic       otp_burn_out,
  input wire logic [7:0] otp_burn_data_out,
  input wire logic [7:0] zero_offset_out,
  input wire logic       fused_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles since release; boot load may move the register early
  logic [3:0] up_cnt;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'hF) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end
  property p_miso_quiet; !spi_miso_oe_out |-> !spi_miso_out; endproperty
  a_miso_quiet: assert property (p_miso_quiet) else $error("miso not low");
  property p_oe_on; spi_cs_n_in ##1 !spi_cs_n_in [*5] |-> spi_miso_oe_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("miso not driven");
  property p_oe_off; !spi_cs_n_in ##1 spi_cs_n_in [*5] |-> !spi_miso_oe_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("miso still driven");
  property p_burn_pulse; otp_burn_out |=> !otp_burn_out; endproperty
  a_burn_pulse: assert property (p_burn_pulse) else $error("burn too long");
  property p_burn_data;
    otp_burn_out |-> fused_out && otp_burn_data_out == zero_offset_out;
  endproperty
  a_burn_data: assert property (p_burn_data) else $error("burn data wrong");
  property p_fuse_sticky; fused_out |=> fused_out; endproperty
  a_fuse_sticky: assert property (p_fuse_sticky) else $error("fuse lost");
  property p_fuse_lock; fused_out ##1 fused_out |-> $stable(zero_offset_out); endproperty
  a_fuse_lock: assert property (p_fuse_lock) else $error("fused reg moved");
  property p_idle_hold;
    (up_cnt == 4'hF && spi_cs_n_in) [*6] |-> $stable(zero_offset_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("reg moved idle");
  c_burn: cover property (otp_burn_out);
  c_frame: cover property ($rose(spi_miso_oe_out));
  c_zero: cover property ($changed(zero_offset_out));
endmodule
bind azs_spi_top azs_spi_top_sva azs_spi_top_sva_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .spi_cs_n_in(spi_cs_n_in),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
  .otp_burn_out(otp_burn_out), .otp_burn_data_out(otp_burn_data_out),
  .zero_offset_out(zero_offset_out), .fused_out(fused_out));

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the angle sensor serial slave.
// Assumes: Front-end divider shortened to 8 clocks.
// Notes:   Each scenario judges its own results.
`timescale 1ns/1ps
module tb;
  import azs_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, otp_fused_in = 1'b0, burn_seen = 1'b0;
  logic sclk, cs_n, mosi, miso, burn, fused;
  logic [7:0] fe_angle_in = 8'h00, otp_zero_in = 8'h00, burn_val, bdata, pwm, zero;
  logic [15:0] rx;
  int n_mismatch = 0, checks_done = 0;
  always #12.5 clk_in = ~clk_in;
  azs_spi_top #(.FE_DIV(8)) azs_spi_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_out(), .fe_angle_in(fe_angle_in), .otp_fused_in(otp_fused_in),
    .otp_zero_in(otp_zero_in), .otp_burn_out(burn), .otp_burn_data_out(bdata),
    .pwm_angle_out(pwm), .zero_offset_out(zero), .fused_out(fused));
  azs_master azs_master_i (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
    .cs_n_out(cs_n), .mosi_out(mosi));
  // Catch the one-cycle burn request
  always @(posedge clk_in) if (burn === 1'b1) begin
    burn_seen <= 1'b1;
    burn_val <= bdata;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic boot(input logic f, input logic [7:0] z);
    @(posedge clk_in);
    otp_fused_in <= f;
    otp_zero_in <= z;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
  endtask
  // New raw angle, then let several samples pass
  task automatic angle(input logic [7:0] a);
    @(posedge clk_in);
    fe_angle_in <= a;
    repeat (24) @(posedge clk_in);
  endtask
  task automatic xf(input logic [15:0] t);
    azs_master_i.xfer(t, rx);
  endtask
  task automatic t_write_read();
    boot(1'b0, 8'h5A);
    chk({fused, zero}, 16'h0000);
    angle(8'h90);
    chk(pwm, 16'h0090);
    xf(16'h2423);
    chk(zero, 16'h0023);
    xf(16'h0000);
    chk(rx, 16'h6D00);
    chk(pwm, 16'h006D);
    xf(16'h14FF);
    chk(rx, 16'h6D23);
    xf(16'h0000);
    chk(rx, 16'h6D00);
    xf(16'h2577);
    chk(zero, 16'h0023);
  endtask
  task automatic t_wrap();
    xf(16'h24FF);
    angle(8'h00);
    xf(16'h0000);
    chk(rx, 16'h0100);
    chk(pwm, 16'h0001);
  endtask
  task automatic t_fuse();
    burn_seen <= 1'b0;
    xf(16'h2910);
    chk({burn_seen, burn_val}, 16'h01FF);
    chk(fused, 16'h0001);
    xf(16'h2412);
    chk(zero, 16'h00FF);
    xf(16'h1900);
    chk(rx, 16'h0100);
  endtask
  task automatic t_fused_boot();
    boot(1'b1, 8'h3C);
    chk({fused, zero}, 16'h013C);
    angle(8'h40);
    xf(16'h2400);
    xf(16'h1400);
    chk(rx, 16'h043C);
  endtask
  // Raw angle moves mid-frame; the frame keeps the frozen value
  task automatic t_freeze();
    fork
      xf(16'h0000);
      begin
        repeat (40) @(posedge clk_in);
        fe_angle_in <= 8'h80;
      end
    join
    chk(rx, 16'h0400);
    xf(16'h0000);
    chk(rx, 16'h4400);
    chk(pwm, 16'h0044);
  endtask
  initial begin
    t_write_read();
    t_wrap();
    t_fuse();
    t_fused_boot();
    t_freeze();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    $display("MISMATCH t=%0t run timed out", $time);
    n_mismatch++;
    wrap_up();
  end
endmodule

// ---- verilog/azs_pkg.sv ----
// Purpose: Shared constants for the angle sensor serial slave with zero offset.
// Assumes: 40 MHz core clock, SPI mode 3 link sampled by that clock.
// Notes:   Every opcode, address and timing count lives here; the top hard-codes the read-header field slices.
package azs_pkg;

  // Core clock and front-end refresh timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned FE_RATE_KHZ = 500;
  localparam int unsigned FE_CYCLES   = CLK_HZ / (FE_RATE_KHZ * 1000);

  // Frame geometry, MSB first
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned OP_MSB     = 15;
  localparam int unsigned OP_LSB     = 12;
  localparam int unsigned ADDR_MSB   = 11;
  localparam int unsigned ADDR_LSB   = 8;
  localparam int unsigned DATA_MSB   = 7;
  localparam int unsigned DATA_LSB   = 0;
  localparam int unsigned HDR_BITS   = 8;

  // Command opcodes
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_READ  = 4'h1;

  // Register addresses and values
  localparam logic [3:0] ADDR_ZERO  = 4'h4;
  localparam logic [3:0] ADDR_FLASH = 4'h9;
  localparam logic [7:0] FLASH_KEY  = 8'h10;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;

  // Zero-offset weight: millidegrees per count
  localparam int unsigned ZERO_MDEG_PER_LSB = 1410;

  // Core state after reset release
  typedef enum logic [1:0] {
    AZS_BOOT = 2'b00,
    AZS_RUN  = 2'b01
  } azs_state_t;

endpackage

// ---- verilog/azs_spi_top.sv ----
// Purpose: SPI mode 3 slave of an angle sensor with programmable zero offset.
// Assumes: Raw angle arrives on the core clock; fuse contents are stable at reset.
// Notes:   SCLK is oversampled, so it must stay well below a quarter of clk_in.
`timescale 1ns/1ps

module azs_spi_top
  import azs_pkg::*;
#(
  parameter int unsigned FE_DIV = FE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // SPI link pins
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_out,
  // Front-end raw angle, core clock domain
  input  wire logic [7:0] fe_angle_in,
  // Fuse memory contents
  input  wire logic       otp_fused_in,
  input  wire logic [7:0] otp_zero_in,
  // Fuse programming request
  output logic            otp_burn_out,
  output logic [7:0]      otp_burn_data_out,
  // Offset angle towards the PWM generator
  output logic [7:0]      pwm_angle_out,
  // Current zero offset and fuse status
  output logic [7:0]      zero_offset_out,
  output logic            fused_out
);

  // Offset subtraction, modulo 256 by width
  function automatic logic [7:0] offset_angle(input logic [7:0] raw, input logic [7:0] zero);
    offset_angle = raw - zero;
  endfunction

  // Register read decode
  function automatic logic [7:0] read_reg(input logic [3:0] addr, input logic [7:0] zero);
    read_reg = (addr == ADDR_ZERO) ? zero : READ_NONE;
  endfunction

  // Write decode: write opcode aimed at the zero register
  function automatic logic is_zero_write(input logic [15:0] word);
    is_zero_write = (word[OP_MSB:OP_LSB] == OP_WRITE)
                    && (word[ADDR_MSB:ADDR_LSB] == ADDR_ZERO);
  endfunction

  // Write decode: flash key written to the fuse register
  function automatic logic is_flash_cmd(input logic [15:0] word);
    is_flash_cmd = (word[OP_MSB:OP_LSB] == OP_WRITE)
                   && (word[ADDR_MSB:ADDR_LSB] == ADDR_FLASH)
                   && (word[DATA_MSB:DATA_LSB] == FLASH_KEY);
  endfunction

  logic [1:0]  rst_pipe;
  logic        rst_n;
  logic [2:0]  pins_sync;
  logic        sclk_s;
  logic        cs_n_s;
  logic        mosi_s;
  logic        sclk_d;
  logic        cs_n_d;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        in_frame;
  azs_state_t  state;
  logic [7:0]  zero_offset_reg;
  logic        fused;
  logic [7:0]  fe_sample;
  logic [7:0]  out_buf;
  logic [$clog2(FE_DIV+1)-1:0] fe_cnt;
  logic        fe_tick;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [4:0]  rx_cnt;
  logic [15:0] next_rx;
  logic        frame_done;
  logic        hdr_done;
  logic        wr_zero;
  logic        wr_flash;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Link pins are asynchronous to clk_in
  azs_sync #(
    .W    (3),
    .INIT (1'b1)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .d_in     ({spi_sclk_in, spi_cs_n_in, spi_mosi_in}),
    .q_out    (pins_sync)
  );
  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Edge history of the synchronised levels
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end
  // Edge strobes count only inside a running frame
  assign in_frame   = !cs_n_s && (state == AZS_RUN);
  assign sclk_rise  = in_frame && !sclk_d && sclk_s;
  assign sclk_fall  = in_frame && sclk_d && !sclk_s;
  assign cs_fall    = cs_n_d && !cs_n_s && (state == AZS_RUN);

  // Shift word and bit-count milestones
  assign next_rx    = {rx_shift[14:0], mosi_s};
  assign frame_done = sclk_rise && (rx_cnt == 5'(FRAME_BITS - 1));
  assign hdr_done   = sclk_rise && (rx_cnt == 5'(HDR_BITS - 1));

  // Commands act on the 16th rise; a fused part decodes no writes
  assign wr_zero    = frame_done && !fused && is_zero_write(next_rx);
  assign wr_flash   = frame_done && !fused && is_flash_cmd(next_rx);

  // Boot: one cycle to copy the fuse image, then run
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= AZS_BOOT;
    end else begin
      case (state)
        AZS_BOOT: state <= AZS_RUN;
        AZS_RUN:  state <= AZS_RUN;
        default:  state <= AZS_BOOT;
      endcase
    end
  end

  // Zero register and fuse flag
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      zero_offset_reg <= ZERO_RESET;
      fused           <= 1'b0;
    end else if (state == AZS_BOOT) begin
      fused           <= otp_fused_in;
      zero_offset_reg <= otp_fused_in ? otp_zero_in : ZERO_RESET;
    end else begin
      if (wr_zero) begin
        zero_offset_reg <= next_rx[DATA_MSB:DATA_LSB];
      end
      if (wr_flash) begin
        fused <= 1'b1;
      end
    end
    // fused register ignores writes via the !fused gate in the decode
  end

  // Fuse burn request, one-cycle pulse with the data to burn
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      otp_burn_out      <= 1'b0;
      otp_burn_data_out <= ZERO_RESET;
    end else begin
      otp_burn_out <= wr_flash;
      // Data tracks the register each cycle, so it is valid with the pulse
      otp_burn_data_out <= zero_offset_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fe_cnt <= '0;
    end else if (fe_cnt == ($bits(fe_cnt))'(FE_DIV - 1)) begin
      fe_cnt <= '0;
    end else begin
      fe_cnt <= fe_cnt + 1'b1;
    end
  end
  assign fe_tick = (fe_cnt == ($bits(fe_cnt))'(FE_DIV - 1));

  // Raw sample register, refreshed on each tick
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fe_sample <= 8'h00;
    end else if (fe_tick) begin
      fe_sample <= fe_angle_in;
    end
  end

  // Output buffer; offset is live so a write shows in the next frame
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_buf <= 8'h00;
    end else if (cs_n_s) begin
      out_buf <= offset_angle(fe_sample, zero_offset_reg);
    end
    // held while chip select is low
  end

  // PWM sees the same offset angle
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwm_angle_out <= 8'h00;
    end else begin
      pwm_angle_out <= offset_angle(fe_sample, zero_offset_reg);
    end
  end

  // Receive shift and bit count; restart with every chip select
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 16'h0000;
      rx_cnt   <= 5'h00;
    end else if (cs_n_s) begin
      rx_cnt <= 5'h00;
    end else if (sclk_rise && rx_cnt != 5'(FRAME_BITS)) begin
      rx_shift <= next_rx;
      rx_cnt   <= rx_cnt + 5'h01;
    end
  end

  // Transmit word: angle byte then reply byte
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
    end else if (cs_fall) begin
      // every frame starts with angle, zero second byte
      tx_shift <= {out_buf, READ_NONE};
    end else if (hdr_done && next_rx[7:4] == OP_READ) begin
      // reply byte from header; tail ignored
      // Eight falls have shifted the word, so the reply lands in the top byte
      tx_shift[15:8] <= read_reg(next_rx[3:0], zero_offset_reg);
    end else if (sclk_fall) begin
      // next bit after each setting edge
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_oe_out <= in_frame;
    end
  end

  // MISO: MSB shown on chip select fall, then per falling edge
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso_out <= 1'b0;
    end else begin
      if (cs_fall) begin
        spi_miso_out <= out_buf[7];
      end else if (sclk_fall) begin
        spi_miso_out <= tx_shift[15];
      end else if (cs_n_s) begin
        spi_miso_out <= 1'b0;
      end
    end
  end

  assign zero_offset_out = zero_offset_reg;
  assign fused_out       = fused;

endmodule

// ---- verilog/azs_sync.sv ----
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherency needed.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module azs_sync #(
  parameter int unsigned W = 1,
  parameter logic        INIT = 1'b1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] stage1;

  // Two stages; idle-high pins reset to INIT
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= {W{INIT}};
      q_out  <= {W{INIT}};
    end else begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end

endmodule
